// file: src/scs_clock_regs.svh
// register addresses, field positions, reset values and fixed constants
`ifndef SCS_CLOCK_REGS_SVH
`define SCS_CLOCK_REGS_SVH

// special function register addresses
`define SCS_ADDR_CLOCK_CONTROL  8'h9A
`define SCS_ADDR_ANALOG_MODE    8'hC5
`define SCS_ADDR_RTC_TRIM       8'h9B
`define SCS_ADDR_STATUS         8'h9C

// reset values
`define SCS_RST_CLOCK_CONTROL   8'h00
`define SCS_RST_ANALOG_MODE     8'h00
`define SCS_RST_RTC_TRIM        8'hA5

// clock control fields
`define SCS_CKC_EMG_BIT         7
`define SCS_CKC_RTC_MODE_BIT    6
`define SCS_CKC_DSP_HI          5
`define SCS_CKC_DSP_LO          4
`define SCS_CKC_MICRO_HI        3
`define SCS_CKC_MICRO_LO        2
`define SCS_CKC_FRAME_HI        1
`define SCS_CKC_FRAME_LO        0

// analog mode fields
`define SCS_SYM_DIV_HI          7
`define SCS_SYM_DIV_LO          6
`define SCS_SYM_PLL_BIT         5

// fixed upper comparator bits q27..q19
`define SCS_CMP_FIXED_358       9'h199
`define SCS_CMP_FIXED_3456      9'h18B

// second periodic event: frames per event
`define SCS_TIME_EVENT_FRAMES   8000

`endif

// file: src/scs_clock_pkg.sv
// types shared by the clock select block
package scs_clock_pkg;
    typedef logic [7:0] scs_byte_t;
    typedef enum logic [1:0] {SCS_MUX_RUN, SCS_MUX_PARK} scs_mux_state_e;
endpackage

// file: src/scs_rtc_if.sv
// link between the clock select top and the real-time-clock divider
`timescale 1ns/1ps
`default_nettype none
interface scs_rtc_if;
    logic       tick;       // one pulse per emergency clock rising edge
    logic       mode_358;   // 1: 3.58 MHz comparator
    logic [7:0] trim;       // comparator bits q18..q11
    logic       minute;     // one-cycle minute event
    modport div (input tick, input mode_358, input trim, output minute);
    modport ctl (output tick, output mode_358, output trim, input minute);
endinterface
`default_nettype wire

// file: src/scs_glitchless_mux.sv
// glitch-free clock source selector, modelled on sampled clock levels
`timescale 1ns/1ps
`default_nettype none
module scs_glitchless_mux #(
    parameter int N = 4
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // sources and selection
    input  wire logic [N-1:0]         src,
    input  wire logic [$clog2(N)-1:0] sel_req,
    // selected clock and switch status
    output logic                      clk_out,
    output logic                      busy
);
    import scs_clock_pkg::*;

    generate
        if (N < 2)
        begin : g_chk
            $error("scs_glitchless_mux needs at least two sources");
        end
    endgenerate

    scs_mux_state_e           state_reg;   // run or parked low
    logic [$clog2(N)-1:0]     cur_reg;     // source now driving

    // switch only while old source is low, resume only while new is low
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= SCS_MUX_RUN;
            cur_reg   <= '0;
            clk_out   <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                SCS_MUX_RUN:
                begin
                    // a change while high would cut the pulse short
                    if (sel_req != cur_reg && !src[cur_reg])
                    begin
                        state_reg <= SCS_MUX_PARK;
                        cur_reg   <= sel_req;
                        clk_out   <= 1'b0;
                    end
                    else
                        clk_out <= src[cur_reg];
                end
                SCS_MUX_PARK:
                begin
                    // hold low until new source is low, no runt high
                    clk_out <= 1'b0;
                    if (sel_req != cur_reg)
                        cur_reg <= sel_req;
                    else if (!src[cur_reg])
                        state_reg <= SCS_MUX_RUN;
                end
            endcase
        end
    end

    assign busy = (state_reg != SCS_MUX_RUN) || (sel_req != cur_reg);
endmodule
`default_nettype wire

// file: src/scs_rtc_divider.sv
// real-time-clock divider: 28-bit counter with trimmed comparator
`timescale 1ns/1ps
`default_nettype none
`include "scs_clock_regs.svh"
module scs_rtc_divider #(
    parameter int CNT_W = 28,
    parameter int CMP_W = 17
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // link to the top
    scs_rtc_if.div    rtc
);
    import scs_clock_pkg::*;

    generate
        if (CNT_W != 28 || CMP_W != 17)
        begin : g_chk
            $error("scs_rtc_divider supports only 28/17 bit layout");
        end
    endgenerate

    logic [CNT_W-1:0] count_reg;   // emergency clock periods
    logic [CMP_W-1:0] compare;     // q27..q11
    logic             match;

    // fixed top bits per crystal, trim fills q18..q11
    assign compare = rtc.mode_358 ? {`SCS_CMP_FIXED_358, rtc.trim}
                                  : {`SCS_CMP_FIXED_3456, rtc.trim};
    // low 11 bits not compared, taken as zero
    assign match = (count_reg[CNT_W-1 -: CMP_W] == compare);

    // count emergency clock edges, restart on match
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= '0;
        else if (rtc.tick)
        begin
            if (match)
                count_reg <= '0;
            else
                count_reg <= count_reg + 1'b1;
        end
    end

    // one-cycle minute pulse on the matching edge
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rtc.minute <= 1'b0;
        else
            rtc.minute <= rtc.tick && match;
    end
endmodule
`default_nettype wire

// file: src/scs_clock_select.sv
// system clock selection, frame timing events and real-time clock
`timescale 1ns/1ps
`default_nettype none
`include "scs_clock_regs.svh"

module scs_clock_select #(
    parameter int TIME_FRAMES = `SCS_TIME_EVENT_FRAMES
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    // special function register port
    input  wire logic [7:0]              sfr_addr,
    input  wire scs_clock_pkg::scs_byte_t sfr_wdata,
    input  wire logic                    sfr_wr,
    input  wire logic                    sfr_rd,
    output scs_clock_pkg::scs_byte_t     sfr_rdata,
    // clock sources
    input  wire logic                    emergency_clock,
    input  wire logic                    tap_1m,
    input  wire logic                    tap_7m,
    input  wire logic                    tap_14m,
    input  wire logic                    tap_21m,
    input  wire logic                    tap_28m,
    input  wire logic                    tap_42m,
    input  wire logic                    codec_clock_freq_corrected,
    input  wire logic                    codec_clock_phase_corrected,
    // frame timing and power state
    input  wire logic                    codec_frame_strobe,
    input  wire logic                    power_down,
    input  wire logic                    system_off,
    // selected clocks
    output logic                         micro_clock,
    output logic                         dsp_clock,
    output logic                         codec_clock,
    // analog controls
    output logic                         pll_enable,
    output logic [2:0]                   input_div_ratio,
    // interrupt events
    output logic                         frame_rate_event,
    output logic                         time_event,
    output logic                         rtc_minute_event,
    output logic                         rtc_wake
);
    import scs_clock_pkg::*;

    localparam int TW = $clog2(TIME_FRAMES);

    generate
        if (TIME_FRAMES < 2)
        begin : g_chk
            $error("TIME_FRAMES must be at least two");
        end
    endgenerate

    // register file
    scs_byte_t clock_control_reg;        // emergency, rtc, dsp, micro, frame select
    scs_byte_t analog_system_mode_reg;   // division select and pll enable
    scs_byte_t rtc_compare_trim;         // comparator trim byte

    // decoded controls
    logic       not_emergency;           // clock control bit 7 set
    logic       rtc_mode_358;            // clock control bit 6
    logic [1:0] dsp_code;
    logic [1:0] micro_code;
    logic [1:0] frame_code;
    logic       pll_on;

    // mux selections and status
    logic [2:0] micro_sel;
    logic [2:0] dsp_sel;
    logic [1:0] codec_sel;
    logic       micro_busy;
    logic       dsp_busy;
    logic       codec_busy;

    // frame event counters
    logic [3:0]    frame_cnt_reg;        // strobes since reset, wrapping at 16
    logic [3:0]    frame_mask;           // wrap mask per rate
    logic [TW-1:0] time_cnt_reg;         // frames since last time event

    // rtc link
    logic     emg_prev_reg;              // last emergency clock level
    scs_rtc_if rtc_link ();

    // register writes
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            clock_control_reg      <= `SCS_RST_CLOCK_CONTROL;
            analog_system_mode_reg <= `SCS_RST_ANALOG_MODE;
            rtc_compare_trim       <= `SCS_RST_RTC_TRIM;
        end
        else if (sfr_wr)
        begin
            unique case (sfr_addr)
                `SCS_ADDR_CLOCK_CONTROL: clock_control_reg      <= sfr_wdata;
                `SCS_ADDR_ANALOG_MODE:   analog_system_mode_reg <= sfr_wdata;
                `SCS_ADDR_RTC_TRIM:      rtc_compare_trim       <= sfr_wdata;
                default:
                begin
                    // other addresses belong to other blocks
                end
            endcase
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
        begin
            unique case (sfr_addr)
                `SCS_ADDR_CLOCK_CONTROL: sfr_rdata <= clock_control_reg;
                `SCS_ADDR_ANALOG_MODE:   sfr_rdata <= analog_system_mode_reg;
                `SCS_ADDR_RTC_TRIM:      sfr_rdata <= rtc_compare_trim;
                // live switch status so software can wait for a settled clock
                `SCS_ADDR_STATUS:
                    sfr_rdata <= {5'h00, codec_busy, dsp_busy, micro_busy};
                default:                 sfr_rdata <= 8'h00;
            endcase
        end
    end

    // field decode
    assign not_emergency = clock_control_reg[`SCS_CKC_EMG_BIT];
    assign rtc_mode_358  = clock_control_reg[`SCS_CKC_RTC_MODE_BIT];
    assign dsp_code      = clock_control_reg[`SCS_CKC_DSP_HI:`SCS_CKC_DSP_LO];
    assign micro_code    = clock_control_reg[`SCS_CKC_MICRO_HI:`SCS_CKC_MICRO_LO];
    assign frame_code    = clock_control_reg[`SCS_CKC_FRAME_HI:`SCS_CKC_FRAME_LO];
    assign pll_on        = analog_system_mode_reg[`SCS_SYM_PLL_BIT];

    // analog control outputs from registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pll_enable      <= 1'b0;
            input_div_ratio <= 3'h1;
        end
        else
        begin
            pll_enable <= pll_on;
            // code 00 is straight through for both standard crystals
            unique case (analog_system_mode_reg[`SCS_SYM_DIV_HI:`SCS_SYM_DIV_LO])
                2'b00:   input_div_ratio <= 3'h1;
                2'b01:   input_div_ratio <= 3'h2;
                2'b10:   input_div_ratio <= 3'h4;
                default: input_div_ratio <= 3'h1;
            endcase
        end
    end

    // micro source: 0 emg, 1..4 taps, 5 none
    always_comb
    begin
        if (!not_emergency)
            micro_sel = 3'h0;
        else if (!pll_on)
            micro_sel = 3'h5; // software must avoid this
        else
            micro_sel = {1'b0, micro_code} + 3'h1;
    end

    // dsp source: 0 emg, 1..4 taps, 5 none
    always_comb
    begin
        if (!not_emergency)
            dsp_sel = 3'h0;
        else if (!pll_on)
            dsp_sel = 3'h5; // no clock active
        else
            dsp_sel = {1'b0, dsp_code} + 3'h1;
    end

    // codec source: 0 emg, 1 freq corrected, 2 phase corrected
    always_comb
    begin
        if (!not_emergency)
            codec_sel = 2'h0; // phase corrected never offered here
        else if (rtc_mode_358)
            codec_sel = 2'h1;
        else
            codec_sel = 2'h2;
    end

    // micro clock net; emergency path works before the pll is up
    scs_glitchless_mux #(.N(6)) u_micro_mux (
        .mclk    (mclk),
        .rstn    (rstn),
        .src     ({1'b0, tap_21m, tap_14m, tap_7m, tap_1m, emergency_clock}),
        .sel_req (micro_sel),
        .clk_out (micro_clock),
        .busy    (micro_busy)
    );

    // dsp clock net; note 42 MHz tap is code 10, 28 MHz is code 11
    scs_glitchless_mux #(.N(6)) u_dsp_mux (
        .mclk    (mclk),
        .rstn    (rstn),
        .src     ({1'b0, tap_28m, tap_42m, tap_7m, tap_1m, emergency_clock}),
        .sel_req (dsp_sel),
        .clk_out (dsp_clock),
        .busy    (dsp_busy)
    );

    // codec clock net; spare input three is held low
    scs_glitchless_mux #(.N(4)) u_codec_mux (
        .mclk    (mclk),
        .rstn    (rstn),
        .src     ({1'b0, codec_clock_phase_corrected,
                   codec_clock_freq_corrected, emergency_clock}),
        .sel_req (codec_sel),
        .clk_out (codec_clock),
        .busy    (codec_busy)
    );

    // wrap mask per rate code
    always_comb
    begin
        unique case (frame_code)
            2'b00: frame_mask = 4'hF; // every 16 frames
            2'b01: frame_mask = 4'h7; // every 8 frames
            2'b10: frame_mask = 4'h3; // every 4 frames
            2'b11: frame_mask = 4'h0; // every frame
        endcase
    end

    // frame counter advances only on the frame strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            frame_cnt_reg <= 4'h0;
        else if (codec_frame_strobe)
            frame_cnt_reg <= frame_cnt_reg + 4'h1;
    end

    // frame event pulse, one clock, aligned to the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            frame_rate_event <= 1'b0;
        else
            frame_rate_event <= codec_frame_strobe
                                && ((frame_cnt_reg & frame_mask) == frame_mask);
    end

    // second periodic event counts frames too
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            time_cnt_reg <= '0;
        else if (codec_frame_strobe)
        begin
            if (time_cnt_reg == TW'(TIME_FRAMES - 1))
                time_cnt_reg <= '0;
            else
                time_cnt_reg <= time_cnt_reg + 1'b1;
        end
    end

    // time event pulse on the wrapping strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            time_event <= 1'b0;
        else
            time_event <= codec_frame_strobe
                          && (time_cnt_reg == TW'(TIME_FRAMES - 1));
    end

    // emergency clock edge detect; independent of pll state
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            emg_prev_reg <= 1'b0;
        else
            emg_prev_reg <= emergency_clock;
    end

    // tick marks each emergency clock rising edge
    assign rtc_link.tick     = emergency_clock && !emg_prev_reg;
    assign rtc_link.mode_358 = rtc_mode_358;
    assign rtc_link.trim     = rtc_compare_trim;

    // minute divider
    scs_rtc_divider #(.CNT_W(28), .CMP_W(17)) u_rtc (
        .mclk (mclk),
        .rstn (rstn),
        .rtc  (rtc_link.div)
    );

    // interrupt line for the minute event
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rtc_minute_event <= 1'b0;
        else
            rtc_minute_event <= rtc_link.minute;
    end

    // wake only from power-down; system-off kills the oscillator anyway
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rtc_wake <= 1'b0;
        else
            rtc_wake <= rtc_link.minute && power_down && !system_off;
    end
endmodule
`default_nettype wire

// file: dv/scs_clock_select_asserts.sv
// concurrent checks on the clock select top ports
`timescale 1ns/1ps
`default_nettype none
`include "scs_clock_regs.svh"
module scs_clock_select_asserts #(
    parameter int TIME_FRAMES = 4
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // register writes
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    // clock sources and frame strobe
    input wire logic       emergency_clock,
    input wire logic       tap_1m,
    input wire logic       tap_7m,
    input wire logic       tap_14m,
    input wire logic       tap_21m,
    input wire logic       tap_28m,
    input wire logic       tap_42m,
    input wire logic       codec_clock_freq_corrected,
    input wire logic       codec_clock_phase_corrected,
    input wire logic       codec_frame_strobe,
    // watched outputs
    input wire logic       micro_clock,
    input wire logic       dsp_clock,
    input wire logic       codec_clock,
    input wire logic       pll_enable,
    input wire logic [2:0] input_div_ratio,
    input wire logic       frame_rate_event,
    input wire logic       time_event,
    input wire logic       rtc_minute_event,
    input wire logic       rtc_wake
);
    import scs_clock_pkg::*;
    scs_byte_t   ckc_reg;   // clock control shadow
    scs_byte_t   sym_reg;   // analog mode shadow
    logic [4:0]  quiet_reg; // cycles since a selection write
    logic [3:0]  fcnt_reg;  // strobes since reset, wrapping
    logic [15:0] tcnt_reg;  // strobes toward the next time event
    logic [3:0]  fmask;     // count bits that must all be set
    logic        fhit;      // this strobe earns a frame event
    logic        thit;      // this strobe earns a time event
    logic        micro_exp; // level the micro clock should copy
    logic        dsp_exp;   // level the dsp clock should copy
    logic        codec_exp; // level the codec clock should copy
    logic [2:0]  div_exp;   // expected division ratio
    wire logic [3:0] micro_taps = {tap_21m, tap_14m, tap_7m, tap_1m};
    wire logic [3:0] dsp_taps   = {tap_28m, tap_42m, tap_7m, tap_1m};

    // shadows rebuilt from bus writes, no probes inside
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
        begin
            ckc_reg <= 8'h00;
            sym_reg <= 8'h00;
        end
        else if (sfr_wr && sfr_addr == `SCS_ADDR_CLOCK_CONTROL)
            ckc_reg <= sfr_wdata;
        else if (sfr_wr && sfr_addr == `SCS_ADDR_ANALOG_MODE)
            sym_reg <= sfr_wdata;

    // a switching mux parks a while; judge it once settled
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
            quiet_reg <= 5'h00;
        else if (sfr_wr && (sfr_addr == `SCS_ADDR_CLOCK_CONTROL
                            || sfr_addr == `SCS_ADDR_ANALOG_MODE))
            quiet_reg <= 5'h00;
        else if (quiet_reg != 5'h1F)
            quiet_reg <= quiet_reg + 5'h01;

    // strobe counters for both periodic events
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
        begin
            fcnt_reg <= 4'h0;
            tcnt_reg <= 16'h0000;
        end
        else if (codec_frame_strobe)
        begin
            fcnt_reg <= fcnt_reg + 4'h1;
            tcnt_reg <= thit ? 16'h0000 : tcnt_reg + 16'h0001;
        end

    // expected levels and events
    always_comb
    begin
        fmask     = (ckc_reg[1:0] == 2'b11) ? 4'h0 : (4'hF >> ckc_reg[1:0]);
        fhit      = (fcnt_reg & fmask) == fmask;
        thit      = tcnt_reg == 16'(TIME_FRAMES - 1);
        micro_exp = ckc_reg[7] ? (sym_reg[5] & micro_taps[ckc_reg[3:2]]) : emergency_clock;
        dsp_exp   = ckc_reg[7] ? (sym_reg[5] & dsp_taps[ckc_reg[5:4]]) : emergency_clock;
        codec_exp = !ckc_reg[7] ? emergency_clock :
                    ckc_reg[6] ? codec_clock_freq_corrected : codec_clock_phase_corrected;
        div_exp   = (sym_reg[7:6] == 2'b01) ? 3'h2 : (sym_reg[7:6] == 2'b10) ? 3'h4 : 3'h1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_micro_source: assert property (quiet_reg == 5'h1F |-> micro_clock == $past(micro_exp))
        else $error("micro clock off its source");
    a_dsp_source: assert property (quiet_reg == 5'h1F |-> dsp_clock == $past(dsp_exp))
        else $error("dsp clock off its source");
    a_codec_source: assert property (quiet_reg == 5'h1F |-> codec_clock == $past(codec_exp))
        else $error("codec clock off its source");
    a_pll_copy: assert property (quiet_reg >= 5'h02 |-> pll_enable == sym_reg[5])
        else $error("pll enable wrong");
    a_div_ratio: assert property (quiet_reg >= 5'h02 |-> input_div_ratio == div_exp)
        else $error("division ratio wrong");
    a_frame_rate: assert property (codec_frame_strobe |=> frame_rate_event == $past(fhit))
        else $error("frame event wrong");
    a_time_event: assert property (codec_frame_strobe |=> time_event == $past(thit))
        else $error("time event wrong");
    a_events_synced: assert property (!codec_frame_strobe |=> !frame_rate_event && !time_event)
        else $error("event without strobe");
    a_minute_pulse: assert property (rtc_minute_event |=> !rtc_minute_event)
        else $error("minute event too long");
    a_wake_gate: assert property (rtc_wake |-> rtc_minute_event)
        else $error("wake without minute event");
endmodule
`default_nettype wire

// file: dv/scs_cpu.sv
// embedded microcontroller model issuing register cycles
`timescale 1ns/1ps
`default_nettype none
`include "scs_clock_regs.svh"
module scs_cpu (
    // clock
    input wire logic       mclk,
    // register port
    output logic [7:0]     sfr_addr,
    output logic [7:0]     sfr_wdata,
    output logic           sfr_wr,
    output logic           sfr_rd,
    input wire logic [7:0] sfr_rdata
);
    import scs_clock_pkg::*;
    initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;

    // one write; idle bus shows inverted values, not stale ones
    task automatic wr(input logic [7:0] a, input scs_byte_t v);
        @(negedge mclk);
        sfr_addr  = a;
        sfr_wdata = v;
        sfr_wr    = 1'b1;
        @(negedge mclk);
        sfr_wr    = 1'b0;
        sfr_addr  = ~a;
        sfr_wdata = ~v;
    endtask

    // one read; data taken once it stands
    task automatic rd(input logic [7:0] a, output scs_byte_t v);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge mclk);
        sfr_rd   = 1'b0;
        sfr_addr = ~a;
        @(negedge mclk);
        v = sfr_rdata;
    endtask

    // pll on before emergency mode is left
    task automatic set_clocks(input scs_byte_t sym, input scs_byte_t ckc);
        wr(`SCS_ADDR_ANALOG_MODE, sym);
        wr(`SCS_ADDR_CLOCK_CONTROL, ckc);
    endtask

    // trim value matching the fitted crystal
    task automatic load_trim(input logic mode_358);
        wr(`SCS_ADDR_RTC_TRIM, mode_358 ? 8'hA5 : 8'h82);
    endtask
endmodule
`default_nettype wire

// file: dv/scs_clock_select_tb.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none
`include "scs_clock_regs.svh"
module scs_clock_select_tb;
    import scs_clock_pkg::*;
    localparam int TF = 4;               // short time-event period
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  sfr_addr;
    scs_byte_t   sfr_wdata, sfr_rdata;
    logic        sfr_wr, sfr_rd;
    logic        codec_frame_strobe = 1'b0;
    logic [10:0] src_reg = 11'h000;      // random source levels and power state
    wire logic   emergency_clock, tap_1m, tap_7m, tap_14m, tap_21m, tap_28m, tap_42m;
    wire logic   codec_clock_freq_corrected, codec_clock_phase_corrected, power_down, system_off;
    logic        micro_clock, dsp_clock, codec_clock, pll_enable;
    logic [2:0]  input_div_ratio;
    logic        frame_rate_event, time_event, rtc_minute_event, rtc_wake;
    int          n_fail = 0, n_compared = 0, cyc = 0, fcount = 0;
    scs_byte_t   d, ckc, sym;

    assign {system_off, power_down, codec_clock_phase_corrected, codec_clock_freq_corrected,
            tap_42m, tap_28m, tap_21m, tap_14m, tap_7m, tap_1m, emergency_clock} = src_reg;

    scs_clock_select #(.TIME_FRAMES(TF)) scs_clock_select_inst (.*);
    scs_cpu scs_cpu_inst (.*);

    always #25 mclk = ~mclk;
    // source levels change at falling edges; no minute falls in the run
    always @(negedge mclk) src_reg <= 11'($urandom);

    // the run needs about 1650 cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk8(input scs_byte_t got, input scs_byte_t exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // levels of {micro, dsp, codec} one cycle after the sources s
    function automatic logic [2:0] exp_clocks(scs_byte_t c, scs_byte_t m, logic [10:0] s);
        logic [3:0] dt;
        dt = {s[5], s[6], s[2], s[1]};
        if (!c[7])
            return {3{s[0]}};
        return {m[5] & s[{1'b0, c[3:2]} + 3'h1], m[5] & dt[c[5:4]], c[6] ? s[7] : s[8]};
    endfunction

    function automatic logic [2:0] exp_div(scs_byte_t m);
        return (m[7:6] == 2'b01) ? 3'h2 : (m[7:6] == 2'b10) ? 3'h4 : 3'h1;
    endfunction

    initial
    begin
        void'($urandom(56));
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        // reset state
        scs_cpu_inst.rd(`SCS_ADDR_CLOCK_CONTROL, d);
        chk8(d, 8'h00, "control reset");
        scs_cpu_inst.rd(`SCS_ADDR_ANALOG_MODE, d);
        chk8(d, 8'h00, "analog reset");
        chk8({5'h00, input_div_ratio}, 8'h01, "reset ratio");
        // trim read-back, then the nominal value
        repeat (3)
        begin
            ckc = 8'($urandom);
            scs_cpu_inst.wr(`SCS_ADDR_RTC_TRIM, ckc);
            scs_cpu_inst.rd(`SCS_ADDR_RTC_TRIM, d);
            chk8(d, ckc, "trim readback");
        end
        scs_cpu_inst.load_trim(1'b1);
        scs_cpu_inst.rd(`SCS_ADDR_RTC_TRIM, d);
        chk8(d, 8'hA5, "nominal trim");
        // read-only status and an unmapped address
        scs_cpu_inst.wr(`SCS_ADDR_STATUS, 8'hFF);
        scs_cpu_inst.rd(`SCS_ADDR_STATUS, d);
        chk8(d, 8'h00, "status settled");
        scs_cpu_inst.rd(8'h10, d);
        chk8(d, 8'h00, "unmapped read");
        // all clock codes, pll off in and out of emergency
        for (int i = 0; i < 20; i++)
        begin
            ckc = {1'(i < 16), 1'(i >> 2), 4'(i), 2'($urandom)};
            sym = {2'(i), 1'(i != 5 && i != 18), 5'h00};
            scs_cpu_inst.set_clocks(sym, ckc);
            repeat (40) @(negedge mclk);
            chk8({5'h00, input_div_ratio}, {5'h00, exp_div(sym)}, "ratio");
            chk1(pll_enable, sym[5], "pll enable");
            scs_cpu_inst.rd(`SCS_ADDR_CLOCK_CONTROL, d);
            chk8(d, ckc, "control readback");
            repeat (12)
            begin
                @(negedge mclk);
                chk8({3'h0, rtc_minute_event, rtc_wake, micro_clock, dsp_clock, codec_clock},
                     {5'h00, exp_clocks(ckc, sym, src_reg)},
                     "clocks");
            end
        end
        // four frame rates, strobes two or more apart
        for (int code = 0; code < 4; code++)
        begin
            scs_cpu_inst.wr(`SCS_ADDR_CLOCK_CONTROL, 8'h80 | 8'(code));
            repeat (36)
            begin
                codec_frame_strobe = 1'b1;
                fcount++;
                @(negedge mclk);
                codec_frame_strobe = 1'b0;
                chk1(frame_rate_event, (fcount % (code == 3 ? 1 : 16 >> code)) == 0, "frame");
                chk1(time_event, (fcount % TF) == 0, "time");
                repeat (1 + $urandom % 3) @(negedge mclk);
            end
        end
        stop_test();
    end
endmodule

bind scs_clock_select scs_clock_select_asserts #(.TIME_FRAMES(TIME_FRAMES)) scs_clock_select_asserts_inst (.*);
`default_nettype wire
